/* File: agd_pkg.sv */
package agd_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_FILT_LEVELS = 8'h08;
  localparam logic [7:0] OFS_FILT_LIMITS = 8'h0c;
  localparam logic [7:0] OFS_FILT_STEPS = 8'h10;
  localparam logic [7:0] OFS_POWER_LEVELS = 8'h14;
  localparam logic [7:0] OFS_POWER_STEPS = 8'h18;
  localparam logic [7:0] OFS_GAIN_LIMITS = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_PEAK_IMM = 0;
  localparam int POS_FILT_IMM = 1;
  localparam int POS_DET_ON = 2;
  localparam int POS_WIN_CODE = 4;
  localparam int POS_QUOTA = 8;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0117;
  localparam logic [21:0] RST_PERIOD = 22'h07800;
  localparam logic [31:0] RST_FILT_LEVELS = 32'h0040_80b5;
  localparam logic [31:0] RST_FILT_LIMITS = 32'h0004_0406;
  localparam logic [31:0] RST_FILT_STEPS = 32'h0204_0202;
  localparam logic [31:0] RST_POWER_LEVELS = 32'h040c_0301;
  localparam logic [31:0] RST_POWER_STEPS = 32'h0402_0204;
  localparam logic [31:0] RST_GAIN_LIMITS = 32'h0000_c3ff;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] power_outer_top_offset;
    logic [6:0] power_inner_top_level;
    logic [6:0] power_inner_bottom_level;
    logic [3:0] power_outer_bottom_offset;
  } agd_power_cfg_s;

  typedef struct packed {
    logic attack;
    logic recover;
    logic [4:0] step;
  } agd_step_s;

  // ----------------------------------------
  // qualification window length in samples
  // ----------------------------------------
  function automatic logic [5:0] window_len(input logic [2:0] code);
    case (code)
      3'h0: window_len = 6'h01;
      3'h1: window_len = 6'h04;
      3'h2: window_len = 6'h08;
      3'h3: window_len = 6'h0c;
      3'h4: window_len = 6'h10;
      3'h5: window_len = 6'h18;
      default: window_len = 6'h20;
    endcase
  endfunction

endpackage

/* File: agd_window_qual.sv */
`timescale 1ns/1ps
module agd_window_qual (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_sample_valid,
  input wire logic [7:0] i_mag,
  input wire logic [7:0] i_level,
  input wire logic [2:0] i_window_code,
  input wire logic [3:0] i_quota,
  output logic o_event
);
  import agd_pkg::*;

  logic [5:0] pos_q, pos_d;
  logic [5:0] hits_q, hits_d;
  logic fired_q, fired_d;
  logic event_q, event_d;
  wire over = i_mag > i_level;
  wire [5:0] hits_inc = hits_q + {5'h0, over};
  wire last = (pos_q + 6'h01) >= window_len(i_window_code);
  wire hit_ok = (hits_inc >= {2'h0, i_quota}) && !fired_q;

  // ----------------------------------------
  // window count, one event per window
  // ----------------------------------------
  always_comb begin
    pos_d = pos_q;
    hits_d = hits_q;
    fired_d = fired_q;
    event_d = 1'b0;
    if (!i_enable) begin
      pos_d = 6'h00;
      hits_d = 6'h00;
      fired_d = 1'b0;
    end else if (i_sample_valid) begin
      event_d = hit_ok;
      fired_d = fired_q | hit_ok;
      hits_d = hits_inc;
      pos_d = pos_q + 6'h01;
      if (last) begin
        pos_d = 6'h00;
        hits_d = 6'h00;
        fired_d = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pos_q <= 6'h00;
      hits_q <= 6'h00;
      fired_q <= 1'b0;
      event_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      hits_q <= hits_d;
      fired_q <= fired_d;
      event_q <= event_d;
    end
  end

  assign o_event = event_q;
endmodule

/* File: agd_power_judge.sv */
`timescale 1ns/1ps
module agd_power_judge (
  input wire logic [6:0] i_power_db,
  input wire agd_pkg::agd_power_cfg_s i_cfg,
  input wire logic [4:0] i_outer_attack,
  input wire logic [4:0] i_inner_attack,
  input wire logic [4:0] i_inner_recover,
  input wire logic [4:0] i_outer_recover,
  output agd_pkg::agd_step_s o_step
);
  import agd_pkg::*;

  // power is in dB below full scale: small value means strong signal
  wire [7:0] top_outer = {1'b0, i_cfg.power_inner_top_level}
    - {4'h0, i_cfg.power_outer_top_offset};
  wire [7:0] bot_outer = {1'b0, i_cfg.power_inner_bottom_level}
    + {4'h0, i_cfg.power_outer_bottom_offset};
  wire [7:0] pwr = {1'b0, i_power_db};
  wire above_inner = pwr < {1'b0, i_cfg.power_inner_top_level};
  wire above_outer = !top_outer[7] && (pwr < top_outer);
  wire below_inner = pwr > {1'b0, i_cfg.power_inner_bottom_level};
  wire below_outer = pwr > bot_outer;

  assign o_step.attack = above_inner | above_outer;
  assign o_step.recover = !(above_inner | above_outer) && below_inner;
  assign o_step.step = above_outer ? i_outer_attack :
    above_inner ? i_inner_attack :
    below_outer ? i_outer_recover :
    below_inner ? i_inner_recover : 5'h00;
endmodule

/* File: agd_decision.sv */
`timescale 1ns/1ps
module agd_decision (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sample_valid,
  input wire logic [7:0] i_filt_mag,
  input wire logic i_peak_over,
  input wire logic i_power_valid,
  input wire logic [6:0] i_power_db,
  output logic [7:0] o_gain_index,
  output logic o_gain_changed,
  output logic o_filt_overrange,
  output logic o_filt_underrange
);
  import agd_pkg::*;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [21:0] period_q;
  logic [31:0] filt_levels_q;
  logic [31:0] filt_limits_q;
  logic [31:0] filt_steps_q;
  logic [31:0] power_levels_q;
  logic [31:0] power_steps_q;
  logic [31:0] gain_limits_q;

  wire peak_immediate_attack = ctrl_q[POS_PEAK_IMM];
  wire filt_immediate_attack = ctrl_q[POS_FILT_IMM];
  wire filt_detector_on = ctrl_q[POS_DET_ON];
  wire [2:0] overload_window_code = ctrl_q[POS_WIN_CODE +: 3];
  wire [3:0] overload_sample_quota = ctrl_q[POS_QUOTA +: 4];
  wire [7:0] filt_high_level = filt_levels_q[7:0];
  wire [7:0] filt_low_level = filt_levels_q[15:8];
  wire [7:0] filt_vlow_level = filt_levels_q[23:16];
  wire [7:0] filt_high_event_limit = filt_limits_q[7:0];
  wire [7:0] filt_low_event_limit = filt_limits_q[15:8];
  wire [7:0] filt_vlow_event_limit = filt_limits_q[23:16];
  wire [4:0] filt_attack_step = filt_steps_q[4:0];
  wire [4:0] filt_low_recover_step = filt_steps_q[12:8];
  wire [4:0] filt_vlow_recover_step = filt_steps_q[20:16];
  wire [4:0] peak_attack_step = filt_steps_q[28:24];
  wire [7:0] gain_max = gain_limits_q[7:0];
  wire [7:0] gain_min = gain_limits_q[15:8];

  agd_power_cfg_s power_cfg;
  assign power_cfg.power_outer_top_offset = power_levels_q[3:0];
  assign power_cfg.power_inner_top_level = power_levels_q[14:8];
  assign power_cfg.power_inner_bottom_level = power_levels_q[22:16];
  assign power_cfg.power_outer_bottom_offset = power_levels_q[27:24];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = i_psel && !i_penable;
  wire access = i_psel && i_penable;
  wire wr = access && i_pwrite;
  wire hit_ctrl = i_paddr == OFS_CTRL;
  wire hit_period = i_paddr == OFS_PERIOD;
  wire hit_flev = i_paddr == OFS_FILT_LEVELS;
  wire hit_flim = i_paddr == OFS_FILT_LIMITS;
  wire hit_fstep = i_paddr == OFS_FILT_STEPS;
  wire hit_plev = i_paddr == OFS_POWER_LEVELS;
  wire hit_pstep = i_paddr == OFS_POWER_STEPS;
  wire hit_glim = i_paddr == OFS_GAIN_LIMITS;
  wire hit_stat = i_paddr == OFS_STATUS;
  wire mapped = hit_ctrl || hit_period || hit_flev || hit_flim || hit_fstep
    || hit_plev || hit_pstep || hit_glim || hit_stat;

  logic [7:0] high_cnt_q, low_cnt_q, vlow_cnt_q;
  logic [7:0] gain_q, gain_d;
  logic [31:0] rd_mux;

  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {20'h0, ctrl_q[11:8], 1'b0, ctrl_q[6:4], 1'b0, ctrl_q[2:0]};
    end else if (hit_period) begin
      rd_mux = {10'h0, period_q};
    end else if (hit_flev) begin
      rd_mux = {8'h0, filt_levels_q[23:0]};
    end else if (hit_flim) begin
      rd_mux = {8'h0, filt_limits_q[23:0]};
    end else if (hit_fstep) begin
      rd_mux = filt_steps_q & 32'h1f1f_1f1f;
    end else if (hit_plev) begin
      rd_mux = power_levels_q & 32'h0f7f_7f0f;
    end else if (hit_pstep) begin
      rd_mux = power_steps_q & 32'h1f1f_1f1f;
    end else if (hit_glim) begin
      rd_mux = {16'h0, gain_limits_q[15:0]};
    end else if (hit_stat) begin
      rd_mux = {vlow_cnt_q, low_cnt_q, high_cnt_q, gain_q};
    end else begin
      rd_mux = 32'h0;
    end
  end

  assign o_pready = access;
  assign o_pslverr = access && !mapped;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (setup) begin
      o_prdata <= i_pwrite ? 32'h0 : rd_mux;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_q <= RST_CTRL;
      period_q <= RST_PERIOD;
      filt_levels_q <= RST_FILT_LEVELS;
      filt_limits_q <= RST_FILT_LIMITS;
      filt_steps_q <= RST_FILT_STEPS;
      power_levels_q <= RST_POWER_LEVELS;
      power_steps_q <= RST_POWER_STEPS;
      gain_limits_q <= RST_GAIN_LIMITS;
    end else if (wr) begin
      if (hit_ctrl) ctrl_q <= i_pwdata;
      if (hit_period) period_q <= i_pwdata[21:0];
      if (hit_flev) filt_levels_q <= i_pwdata;
      if (hit_flim) filt_limits_q <= i_pwdata;
      if (hit_fstep) filt_steps_q <= i_pwdata;
      if (hit_plev) power_levels_q <= i_pwdata;
      if (hit_pstep) power_steps_q <= i_pwdata;
      if (hit_glim) gain_limits_q <= i_pwdata;
    end
  end

  // ----------------------------------------
  // gain update period
  // ----------------------------------------
  logic [21:0] period_cnt_q;
  wire period_end = period_cnt_q >= (period_q - 22'h1);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      period_cnt_q <= 22'h0;
    end else begin
      period_cnt_q <= period_end ? 22'h0 : period_cnt_q + 22'h1;
    end
  end

  // ----------------------------------------
  // overload qualification per level
  // ----------------------------------------
  wire [7:0] levels [3];
  wire [2:0] evt;
  assign levels[0] = filt_high_level;
  assign levels[1] = filt_low_level;
  assign levels[2] = filt_vlow_level;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_qual
      agd_window_qual u_qual (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_enable(filt_detector_on),
        .i_sample_valid(i_sample_valid),
        .i_mag(i_filt_mag),
        .i_level(levels[g]),
        .i_window_code(overload_window_code),
        .i_quota(overload_sample_quota),
        .o_event(evt[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // per-period event counters
  // ----------------------------------------
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic e);
    sat_inc = (e && v != 8'hff) ? v + 8'h01 : v;
  endfunction

  always_ff @(posedge i_clock) begin
    if (i_rst || period_end) begin
      high_cnt_q <= 8'h0;
      low_cnt_q <= 8'h0;
      vlow_cnt_q <= 8'h0;
    end else begin
      high_cnt_q <= sat_inc(high_cnt_q, evt[0]);
      low_cnt_q <= sat_inc(low_cnt_q, evt[1]);
      vlow_cnt_q <= sat_inc(vlow_cnt_q, evt[2]);
    end
  end

  // ----------------------------------------
  // peak detector input sync and edge
  // ----------------------------------------
  logic peak_s1_q, peak_s2_q, peak_s3_q;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      peak_s1_q <= 1'b0;
      peak_s2_q <= 1'b0;
      peak_s3_q <= 1'b0;
    end else begin
      peak_s1_q <= i_peak_over;
      peak_s2_q <= peak_s1_q;
      peak_s3_q <= peak_s2_q;
    end
  end

  wire peak_rise = peak_s2_q && !peak_s3_q;

  // ----------------------------------------
  // overrange / underrange conditions
  // ----------------------------------------
  logic filt_over_seen_q, peak_over_seen_q;
  logic filt_pend_q, peak_pend_q;
  wire filt_over = filt_detector_on && (high_cnt_q > filt_high_event_limit);
  wire filt_over_new = filt_over && !filt_over_seen_q;
  wire peak_over_new = peak_rise && !peak_over_seen_q;
  wire vlow_under = filt_detector_on && (vlow_cnt_q < filt_vlow_event_limit);
  wire low_under = filt_detector_on && (low_cnt_q < filt_low_event_limit);

  // power measurement held until period end
  logic [6:0] power_q;
  logic power_ok_q;
  agd_step_s pstep;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      power_q <= 7'h0;
      power_ok_q <= 1'b0;
    end else if (i_power_valid) begin
      power_q <= i_power_db;
      power_ok_q <= 1'b1;
    end else if (period_end) begin
      power_ok_q <= 1'b0;
    end
  end

  agd_power_judge u_power (
    .i_power_db(power_q),
    .i_cfg(power_cfg),
    .i_outer_attack(power_steps_q[4:0]),
    .i_inner_attack(power_steps_q[12:8]),
    .i_inner_recover(power_steps_q[20:16]),
    .i_outer_recover(power_steps_q[28:24]),
    .o_step(pstep)
  );

  // ----------------------------------------
  // step selection
  // ----------------------------------------
  wire imm_peak = peak_over_new && peak_immediate_attack;
  wire imm_filt = filt_over_new && filt_immediate_attack;
  wire end_peak = period_end && (peak_pend_q || (peak_over_new && !peak_immediate_attack));
  wire end_filt = period_end && (filt_pend_q || (filt_over_new && !filt_immediate_attack));
  logic dec;
  logic [4:0] step;
  logic apply;

  always_comb begin
    apply = 1'b1;
    dec = 1'b1;
    step = 5'h0;
    if (imm_peak || end_peak) begin
      step = peak_attack_step;
    end else if (imm_filt || end_filt) begin
      step = filt_attack_step;
    end else if (period_end && power_ok_q && pstep.attack) begin
      step = pstep.step;
    end else if (period_end && vlow_under) begin
      dec = 1'b0;
      step = filt_vlow_recover_step;
    end else if (period_end && low_under) begin
      dec = 1'b0;
      step = filt_low_recover_step;
    end else if (period_end && power_ok_q && pstep.recover) begin
      dec = 1'b0;
      step = pstep.step;
    end else begin
      apply = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst || period_end) begin
      filt_over_seen_q <= 1'b0;
      peak_over_seen_q <= 1'b0;
      filt_pend_q <= 1'b0;
      peak_pend_q <= 1'b0;
    end else begin
      filt_over_seen_q <= filt_over_seen_q | filt_over;
      peak_over_seen_q <= peak_over_seen_q | peak_rise;
      filt_pend_q <= filt_pend_q | (filt_over_new && !filt_immediate_attack);
      peak_pend_q <= peak_pend_q | (peak_over_new && !peak_immediate_attack);
    end
  end

  // ----------------------------------------
  // gain index with clamp
  // ----------------------------------------
  wire [9:0] g_ext = {2'b00, gain_q};
  wire [9:0] g_raw = dec ? g_ext - {5'h0, step} : g_ext + {5'h0, step};
  wire g_neg = g_raw[9];
  wire g_low = g_neg || (g_raw[8:0] < {1'b0, gain_min});
  wire g_high = !g_neg && (g_raw[8:0] > {1'b0, gain_max});

  always_comb begin
    gain_d = gain_q;
    if (apply) begin
      if (g_low) begin
        gain_d = gain_min;
      end else if (g_high) begin
        gain_d = gain_max;
      end else begin
        gain_d = g_raw[7:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      gain_q <= RST_GAIN_LIMITS[7:0];
      o_gain_changed <= 1'b0;
      o_filt_overrange <= 1'b0;
      o_filt_underrange <= 1'b0;
    end else begin
      gain_q <= gain_d;
      o_gain_changed <= apply && (gain_d != gain_q);
      o_filt_overrange <= filt_over;
      o_filt_underrange <= period_end ? (vlow_under || low_under) : o_filt_underrange;
    end
  end

  assign o_gain_index = gain_q;
endmodule

/* File: agd_decision_monitor.sv */
`timescale 1ns/1ps
module agd_decision_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_sample_valid,
  input wire logic [7:0] o_gain_index,
  input wire logic o_gain_changed,
  input wire logic o_filt_overrange
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ----------------------------------------
  // cycles since the last valid sample
  // ----------------------------------------
  logic [3:0] since_q;
  logic [3:0] since_d;
  assign since_d = i_sample_valid ? 4'h0 : ((since_q == 4'hf) ? 4'hf : since_q + 4'h1);
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      since_q <= 4'hf;
    end else begin
      since_q <= since_d;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_ready;
    o_pready == (i_psel && i_penable);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not tied to access phase");

  property p_err_phase;
    o_pslverr |-> (i_psel && i_penable);
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("error outside access phase");

  property p_unmapped;
    (i_psel && i_penable && i_paddr > 8'h20) |-> (o_pslverr && o_prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_mapped;
    (i_psel && i_penable && i_paddr <= 8'h20 && i_paddr[1:0] == 2'b00) |-> !o_pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");

  property p_rdata_hold;
    !(i_psel && !i_penable) |=> $stable(o_prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without setup");

  property p_change_flag;
    ($changed(o_gain_index) && !$past(i_rst)) |-> o_gain_changed;
  endproperty
  a_change_flag: assert property (p_change_flag)
    else $error("gain moved without change pulse");

  property p_step_size;
    ($changed(o_gain_index) && !$past(i_rst)) |->
      ((o_gain_index > $past(o_gain_index)) ? (o_gain_index - $past(o_gain_index))
        : ($past(o_gain_index) - o_gain_index)) <= 8'h1f;
  endproperty
  a_step_size: assert property (p_step_size)
    else $error("gain step above 31");

  property p_over_cause;
    $rose(o_filt_overrange) |-> since_q <= 4'h6;
  endproperty
  a_over_cause: assert property (p_over_cause)
    else $error("overrange without recent samples");
endmodule

/* File: agd_datapath_model.sv */
`timescale 1ns/1ps
module agd_datapath_model (
  input wire logic i_clock,
  input wire logic i_burst,
  input wire logic [7:0] i_mag,
  input wire logic i_peak,
  input wire logic i_fire,
  input wire logic [6:0] i_db,
  output logic o_sample_valid,
  output logic [7:0] o_filt_mag,
  output logic o_peak_over,
  output logic o_power_valid,
  output logic [6:0] o_power_db
);
  initial begin
    o_sample_valid = 1'b0;
    o_filt_mag = 8'h00;
    o_peak_over = 1'b0;
    o_power_valid = 1'b0;
    o_power_db = 7'h00;
  end
  // idle buses toggle so stale values are never mistaken for data
  always @(posedge i_clock) begin
    o_sample_valid <= i_burst;
    o_filt_mag <= i_burst ? i_mag : ~o_filt_mag;
    o_peak_over <= i_peak;
    o_power_valid <= i_fire;
    o_power_db <= i_fire ? i_db : ~o_power_db;
  end
endmodule

/* File: tb_agd_decision.sv */
`timescale 1ns/1ps
module tb_agd_decision;
  import agd_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, serr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sv, po, pv, chg, ovr, und;
  logic burst = 1'b0, peak = 1'b0, fire = 1'b0;
  logic [7:0] mag = 8'h00, fm, gain, g;
  logic [6:0] db = 7'h00, pd;
  logic [6:0] pdb [4] = '{7'h01, 7'h02, 7'h0e, 7'h14};
  int pdel [4] = '{-4, -2, 2, 4};
  int err_total = 0, comparisons = 0, cyc = 0, t0 = 0;

  always #5 i_clock = ~i_clock;

  agd_datapath_model u_model (.i_clock(i_clock), .i_burst(burst), .i_mag(mag), .i_peak(peak),
    .i_fire(fire), .i_db(db), .o_sample_valid(sv), .o_filt_mag(fm), .o_peak_over(po),
    .o_power_valid(pv), .o_power_db(pd));

  agd_decision u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sample_valid(sv), .i_filt_mag(fm), .i_peak_over(po),
    .i_power_valid(pv), .i_power_db(pd), .o_gain_index(gain), .o_gain_changed(chg),
    .o_filt_overrange(ovr), .o_filt_underrange(und));

  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    pen <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic send(input int n);
    mag <= 8'hff;
    burst <= 1'b1;
    repeat (n) @(posedge i_clock);
    burst <= 1'b0;
    @(posedge i_clock);
  endtask

  // waits for the next gain move and checks it against the clamped expectation
  task automatic step(input int d, input int lo);
    int n;
    int e;
    n = 0;
    while (chg !== 1'b1 && n < 400) begin
      @(posedge i_clock);
      n++;
    end
    e = g + d;
    if (e > 255) e = 255;
    if (e < 195) e = 195;
    g = e[7:0];
    chk(n >= lo, 1'b1);
    chk(gain, g);
    @(posedge i_clock);
  endtask

  task automatic quiet(input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge i_clock);
      if (chg !== 1'b0) c++;
    end
    chk(c, 0);
  endtask

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    g = 8'hff;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    chk(gain, 8'hff);
    rd(OFS_CTRL, RST_CTRL);
    rd(OFS_FILT_LIMITS, RST_FILT_LIMITS);
    rd(OFS_FILT_STEPS, RST_FILT_STEPS);
    rd(OFS_POWER_LEVELS, RST_POWER_LEVELS);
    rd(8'h40, 32'h0);
    chk(serr, 1'b1);
    wr(OFS_PERIOD, 32'h0000_00c8);
    wr(OFS_FILT_LIMITS, 32'h0);
    t0 = cyc;
    send(3);
    step(-2, 0);
    chk(cyc - t0 < 12, 1'b1);
    chk(ovr, 1'b1);
    rd(OFS_STATUS, 32'h0101_01fd);
    quiet(450);
    chk(ovr, 1'b0);
    wr(OFS_CTRL, 32'h115);
    send(3);
    step(-2, 5);
    wr(OFS_CTRL, 32'h113);
    send(3);
    quiet(450);
    wr(OFS_FILT_LIMITS, 32'h2);
    wr(OFS_CTRL, 32'h127);
    send(4);
    quiet(450);
    wr(OFS_CTRL, 32'h207);
    send(4);
    quiet(450);
    wr(OFS_CTRL, 32'h107);
    send(4);
    step(-2, 0);
    wr(OFS_CTRL, 32'h117);
    wr(OFS_FILT_LIMITS, 32'h0000_04ff);
    step(2, 0);
    chk(und, 1'b1);
    step(2, 0);
    wr(OFS_FILT_LIMITS, 32'h0004_00ff);
    step(4, 0);
    wr(OFS_FILT_LIMITS, 32'h0);
    wr(OFS_CTRL, 32'h114);
    wr(OFS_FILT_STEPS, 32'h0504_0202);
    peak <= 1'b1;
    send(3);
    step(-5, 5);
    peak <= 1'b0;
    quiet(450);
    wr(OFS_CTRL, 32'h117);
    t0 = cyc;
    peak <= 1'b1;
    step(-5, 0);
    chk(cyc - t0 < 12, 1'b1);
    peak <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      db <= pdb[k];
      fire <= 1'b1;
      @(posedge i_clock);
      fire <= 1'b0;
      step(pdel[k], 0);
    end
    complete_run();
  end
endmodule

bind agd_decision agd_decision_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid), .o_gain_index(o_gain_index),
  .o_gain_changed(o_gain_changed), .o_filt_overrange(o_filt_overrange));
